// *** verilog/ctp_pkg.sv ***
package ctp_pkg;
  // data path widths
  localparam int CTP_CNT_W = 16;
  localparam int CTP_PRE_W = 2;
  localparam int CTP_PRIO_W = 3;
  localparam int CTP_DIV_W = 8;
  // reset and limit values
  localparam logic [15:0] CTP_CNT_RST = 16'h0000;
  localparam logic [15:0] CTP_CNT_MAX = 16'hffff;
  localparam logic [2:0] CTP_PRIO_RST = 3'h0;
  localparam logic [7:0] CTP_DIV_RST = 8'h00;
  localparam logic [7:0] CTP_DIV_ONE = 8'h01;
  // prescale ratios for each prescale_select code
  localparam logic [7:0] CTP_RATIO0 = 8'h01;
  localparam logic [7:0] CTP_RATIO1 = 8'h04;
  localparam logic [7:0] CTP_RATIO2 = 8'h10;
  localparam logic [7:0] CTP_RATIO3 = 8'h40;
  // pair numbers with special trigger duties
  localparam int CTP_PAIR_FIRST = 0;
  localparam int CTP_PAIR_SECOND = 1;

  // pair configuration
  typedef enum logic {
    CTP_SPLIT = 1'b0,
    CTP_CASCADE = 1'b1
  } ctp_mode_type;

  // count equals period
  function automatic logic ctp_hit(input logic [15:0] cnt, input logic [15:0] per);
    ctp_hit = (cnt == per);
  endfunction
endpackage

// *** verilog/ctp_prescaler.sv ***
`timescale 1ns/1ns
module ctp_prescaler
  import ctp_pkg::*;
#(
  parameter logic [7:0] RATIO0 = CTP_RATIO0,
  parameter logic [7:0] RATIO1 = CTP_RATIO1,
  parameter logic [7:0] RATIO2 = CTP_RATIO2,
  parameter logic [7:0] RATIO3 = CTP_RATIO3
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // configuration
  input wire logic run_i,
  input wire logic [1:0] prescale_select_i,
  input wire logic clock_source_select_i,
  input wire logic gate_enable_i,
  // pins
  input wire logic ext_clk_i,
  input wire logic gate_i,
  // events
  output logic tick_o,
  output logic gate_fall_o
);
  logic ext_d_r;
  logic gate_d_r;
  logic [7:0] div_cnt_r;
  logic [7:0] ratio;
  logic src_evt;

  // ratio decode
  always_comb begin
    case (prescale_select_i)
      2'h0: ratio = RATIO0;
      2'h1: ratio = RATIO1;
      2'h2: ratio = RATIO2;
      default: ratio = RATIO3;
    endcase
  end

  // source: external rising edge, or internal clock qualified by the gate
  assign src_evt = clock_source_select_i ? (ext_clk_i & ~ext_d_r)
                                         : (~gate_enable_i | gate_i);

  // pin history for edge detection
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ext_d_r <= 1'b0;
      gate_d_r <= 1'b0;
    end else begin
      ext_d_r <= ext_clk_i;
      gate_d_r <= gate_i;
    end
  end

  // divider, cleared while stopped so the first tick is a full period
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !run_i) begin
      div_cnt_r <= CTP_DIV_RST;
      tick_o <= 1'b0;
    end else if (src_evt) begin
      if (div_cnt_r >= ratio - CTP_DIV_ONE) begin
        div_cnt_r <= CTP_DIV_RST;
        tick_o <= 1'b1;
      end else begin
        div_cnt_r <= div_cnt_r + CTP_DIV_ONE;
        tick_o <= 1'b0;
      end
    end else begin
      tick_o <= 1'b0;
    end
  end

  // end of a gated accumulation window
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      gate_fall_o <= 1'b0;
    end else begin
      gate_fall_o <= run_i & ~clock_source_select_i & gate_enable_i
                     & gate_d_r & ~gate_i;
    end
  end
endmodule

// *** verilog/ctp_count16.sv ***
`timescale 1ns/1ns
module ctp_count16
  import ctp_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // controls
  input wire logic inc_i,
  input wire logic clr_i,
  input wire logic wr_i,
  input wire logic [15:0] wdata_i,
  // state
  output logic [15:0] count_o
);
  // software write first, then wrap, then advance
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      count_o <= CTP_CNT_RST;
    end else if (wr_i) begin
      count_o <= wdata_i;
    end else if (clr_i) begin
      count_o <= CTP_CNT_RST;
    end else if (inc_i) begin
      count_o <= count_o + 16'h0001;
    end
  end
endmodule

// *** verilog/ctp_timer_pair.sv ***
`timescale 1ns/1ns
// How it works
// - pair runs as two 16-bit timers, one 32-bit timer or 32-bit counter
// - split halves each offer every 16-bit mode except asynchronous counting
// - in 32-bit mode even half is low word, odd half high word
// - in 32-bit mode odd control bits are ignored; even control governs
// - 32-bit mode uses even clock and gate, raises odd interrupt flag
// - 32-bit period is odd period high word, even period low word
// - count pair always holds odd count high, even count low
// - cascade_select set gives 32-bit pair, cleared gives two 16-bit timers
// - two-bit prescale_select sets ratio; even field serves 32-bit pair
// - clock_source_select and gate_enable choose clock and gated accumulation
// - 32-bit mode interrupts when 32-bit count matches 32-bit period
// - each interrupt has enable and 3-bit priority; odd ones govern pair
// - timers keep running in processor idle and sleep states
// - only first pair supplies time base to capture and compare units
// - first pair triggers converter one, second pair triggers converter two
// - only timers two and three drive DMA requests
// - every 16-bit timer works as synchronous timer or synchronous counter
module ctp_timer_pair
  import ctp_pkg::*;
#(
  parameter int PAIR_INDEX = 0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // even timer control
  input wire logic even_timer_on_i,
  input wire logic even_cascade_select_i,
  input wire logic [1:0] even_prescale_select_i,
  input wire logic even_clock_source_select_i,
  input wire logic even_gate_enable_i,
  // odd timer control
  input wire logic odd_timer_on_i,
  input wire logic [1:0] odd_prescale_select_i,
  input wire logic odd_clock_source_select_i,
  input wire logic odd_gate_enable_i,
  // period values
  input wire logic [15:0] even_period_value_i,
  input wire logic [15:0] odd_period_value_i,
  // count writes
  input wire logic even_count_wr_i,
  input wire logic odd_count_wr_i,
  input wire logic [15:0] count_wdata_i,
  // interrupt control
  input wire logic even_timer_irq_enable_i,
  input wire logic [2:0] even_timer_irq_priority_i,
  input wire logic odd_timer_irq_enable_i,
  input wire logic [2:0] odd_timer_irq_priority_i,
  input wire logic even_irq_flag_clr_i,
  input wire logic odd_irq_flag_clr_i,
  // pins
  input wire logic even_ext_clk_i,
  input wire logic even_gate_i,
  input wire logic odd_ext_clk_i,
  input wire logic odd_gate_i,
  // count values
  output logic [15:0] even_count_value_o,
  output logic [15:0] odd_count_value_o,
  // interrupts
  output logic even_irq_flag_o,
  output logic odd_irq_flag_o,
  output logic even_irq_req_o,
  output logic odd_irq_req_o,
  output logic [2:0] even_irq_priority_o,
  output logic [2:0] odd_irq_priority_o,
  // triggers
  output logic adc1_trigger_o,
  output logic adc2_trigger_o,
  output logic even_dma_req_o,
  output logic odd_dma_req_o,
  // capture and compare time base
  output logic [15:0] even_time_base_o,
  output logic [15:0] odd_time_base_o,
  output logic even_time_base_tick_o,
  output logic odd_time_base_tick_o
);
  localparam bit IS_FIRST = (PAIR_INDEX == CTP_PAIR_FIRST);
  localparam bit IS_SECOND = (PAIR_INDEX == CTP_PAIR_SECOND);

  // configuration seen by each half
  ctp_mode_type mode;
  logic casc;
  logic [1:0] run;
  logic [1:0] pre_sel [2];
  logic [1:0] css;
  logic [1:0] gate_en;
  logic [1:0] ext_clk;
  logic [1:0] gate_pin;

  // prescaler events and counter controls
  logic [1:0] tick;
  logic [1:0] gate_fall;
  logic [1:0] inc;
  logic [1:0] clr;
  logic [1:0] wr;

  // counts, periods and matches
  logic [15:0] cnt [2];
  logic [15:0] per [2];
  logic [1:0] hit16;
  logic hit32;
  logic wrap32;
  logic [1:0] wrap16;
  logic low_full;

  // flags, trigger registers and advance pulses
  logic [1:0] flag_set;
  logic [1:0] flag_clr;
  logic [1:0] flag_r;
  logic [1:0] irq_en;
  logic pair_evt;
  logic adc1_r;
  logic adc2_r;
  logic [1:0] dma_r;
  logic [1:0] adv;

  // configuration selected by the cascade bit
  assign mode = ctp_mode_type'(even_cascade_select_i);
  assign casc = (mode == CTP_CASCADE);

  // odd control bits read as zero while the pair runs cascaded
  function automatic logic ctp_odd_ctl(input logic cascaded, input logic value);
    ctp_odd_ctl = cascaded ? 1'b0 : value;
  endfunction

  // run controls, odd ones masked entirely while cascaded
  assign run[0] = even_timer_on_i;
  assign run[1] = ctp_odd_ctl(casc, odd_timer_on_i);

  // prescaler and clock source selects
  assign pre_sel[0] = even_prescale_select_i;
  assign pre_sel[1] = {ctp_odd_ctl(casc, odd_prescale_select_i[1]),
                       ctp_odd_ctl(casc, odd_prescale_select_i[0])};
  assign css[0] = even_clock_source_select_i;
  assign css[1] = ctp_odd_ctl(casc, odd_clock_source_select_i);

  // gate controls and pin inputs
  assign gate_en[0] = even_gate_enable_i;
  assign gate_en[1] = ctp_odd_ctl(casc, odd_gate_enable_i);
  assign ext_clk[0] = even_ext_clk_i;
  assign ext_clk[1] = ctp_odd_ctl(casc, odd_ext_clk_i);
  assign gate_pin[0] = even_gate_i;
  assign gate_pin[1] = ctp_odd_ctl(casc, odd_gate_i);

  // period values and count writes
  assign per[0] = even_period_value_i;
  assign per[1] = odd_period_value_i;
  assign wr[0] = even_count_wr_i;
  assign wr[1] = odd_count_wr_i;

  // interrupt enables
  assign irq_en[0] = even_timer_irq_enable_i;
  assign irq_en[1] = odd_timer_irq_enable_i;

  // one prescaler per half; each half alone has all synchronous modes
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_half
      ctp_prescaler u_pre (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .run_i(run[gi]),
        .prescale_select_i(pre_sel[gi]),
        .clock_source_select_i(css[gi]),
        .gate_enable_i(gate_en[gi]),
        .ext_clk_i(ext_clk[gi]),
        .gate_i(gate_pin[gi]),
        .tick_o(tick[gi]),
        .gate_fall_o(gate_fall[gi])
      );

      ctp_count16 u_cnt (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .inc_i(inc[gi]),
        .clr_i(clr[gi]),
        .wr_i(wr[gi]),
        .wdata_i(count_wdata_i),
        .count_o(cnt[gi])
      );

      // match and wrap of this half alone
      assign hit16[gi] = ctp_hit(cnt[gi], per[gi]);
      assign wrap16[gi] = tick[gi] & hit16[gi];
    end
  endgenerate

  // 32-bit compare: odd words high, even words low
  assign hit32 = ctp_hit(cnt[1], per[1]) & ctp_hit(cnt[0], per[0]);
  assign wrap32 = tick[0] & hit32;
  assign low_full = (cnt[0] == CTP_CNT_MAX);

  // advance and wrap controls of each half
  always_comb begin
    if (casc) begin
      inc[0] = tick[0];
      clr[0] = wrap32;
      inc[1] = tick[0] & low_full;
      clr[1] = wrap32;
    end else begin
      inc[0] = tick[0];
      clr[0] = wrap16[0];
      inc[1] = tick[1];
      clr[1] = wrap16[1];
    end
  end

  // flag sources: period match or end of a gate window
  always_comb begin
    if (casc) begin
      flag_set[0] = 1'b0;
      flag_set[1] = wrap32 | gate_fall[0];
      pair_evt = wrap32;
    end else begin
      flag_set[0] = wrap16[0] | gate_fall[0];
      flag_set[1] = wrap16[1] | gate_fall[1];
      pair_evt = wrap16[1];
    end
  end

  // flag clears and advance pulses
  assign flag_clr[0] = even_irq_flag_clr_i;
  assign flag_clr[1] = odd_irq_flag_clr_i;
  assign adv[0] = inc[0] | clr[0];
  assign adv[1] = inc[1] | clr[1];

  // sticky flags, a new event wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      flag_r <= 2'h0;
    end else begin
      flag_r <= flag_set | (flag_r & ~flag_clr);
    end
  end

  // interrupt requests and priorities
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      even_irq_req_o <= 1'b0;
      odd_irq_req_o <= 1'b0;
      even_irq_priority_o <= CTP_PRIO_RST;
      odd_irq_priority_o <= CTP_PRIO_RST;
    end else begin
      even_irq_req_o <= flag_r[0] & irq_en[0] & ~casc;
      odd_irq_req_o <= flag_r[1] & irq_en[1];
      even_irq_priority_o <= even_timer_irq_priority_i;
      odd_irq_priority_o <= odd_timer_irq_priority_i;
    end
  end

  // flags and counts straight from their registers
  assign even_irq_flag_o = flag_r[0];
  assign odd_irq_flag_o = flag_r[1];
  assign even_count_value_o = cnt[0];
  assign odd_count_value_o = cnt[1];

  // converter triggers, one converter per designated pair
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      adc1_r <= 1'b0;
      adc2_r <= 1'b0;
    end else begin
      adc1_r <= IS_FIRST & pair_evt;
      adc2_r <= IS_SECOND & pair_evt;
    end
  end

  // trigger outputs
  assign adc1_trigger_o = adc1_r;
  assign adc2_trigger_o = adc2_r;

  // dma requests exist only on the first pair
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      dma_r <= 2'h0;
    end else begin
      dma_r <= IS_FIRST ? flag_set : 2'h0;
    end
  end

  // dma outputs
  assign even_dma_req_o = dma_r[0];
  assign odd_dma_req_o = dma_r[1];

  // time base copies for capture and compare units
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !IS_FIRST) begin
      even_time_base_o <= CTP_CNT_RST;
      odd_time_base_o <= CTP_CNT_RST;
      even_time_base_tick_o <= 1'b0;
      odd_time_base_tick_o <= 1'b0;
    end else begin
      even_time_base_o <= cnt[0];
      odd_time_base_o <= cnt[1];
      even_time_base_tick_o <= adv[0];
      odd_time_base_tick_o <= adv[1];
    end
  end
endmodule

// *** verification/ctp_timer_pair_asserts.sv ***
`timescale 1ns/1ns
module ctp_timer_pair_asserts #(
  parameter int PAIR_INDEX = 0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // watched controls
  input wire logic even_timer_on_i,
  input wire logic even_cascade_select_i,
  input wire logic even_gate_enable_i,
  input wire logic even_count_wr_i,
  input wire logic odd_count_wr_i,
  input wire logic odd_timer_irq_enable_i,
  input wire logic odd_irq_flag_clr_i,
  // watched outputs
  input wire logic [15:0] even_count_value_o,
  input wire logic [15:0] odd_count_value_o,
  input wire logic even_irq_flag_o,
  input wire logic odd_irq_flag_o,
  input wire logic odd_irq_req_o,
  input wire logic adc2_trigger_o,
  input wire logic even_dma_req_o
);
  // one clock domain
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_adc2_wrong_pair: assert property ((PAIR_INDEX != 1) |-> !adc2_trigger_o)
    else $error("converter two trigger from wrong pair");
  a_even_flag_quiet: assert property ($rose(even_irq_flag_o) |-> !$past(even_cascade_select_i))
    else $error("even flag set while cascaded");
  a_req_follows_flag: assert property (
    $rose(odd_irq_flag_o) && odd_timer_irq_enable_i |=> odd_irq_req_o)
    else $error("odd request missing after flag");
  a_carry_same_tick: assert property (
    $past(even_cascade_select_i) && !$past(odd_count_wr_i) && !$past(even_count_wr_i)
    && $past(even_count_value_o) == 16'hffff && even_count_value_o == 16'h0000
    |-> odd_count_value_o == $past(odd_count_value_o) + 16'h0001
    || odd_count_value_o == 16'h0000)
    else $error("carry into high word lost");
  a_odd_moves_carry: assert property (
    $past(even_cascade_select_i) && !$past(odd_count_wr_i) && !$past(sys_rst_i)
    && !$stable(odd_count_value_o) |-> even_count_value_o == 16'h0000)
    else $error("high word moved without carry");
  a_match_clears: assert property (
    $rose(odd_irq_flag_o) && $past(even_cascade_select_i) && !$past(even_gate_enable_i)
    |-> {odd_count_value_o, even_count_value_o} == 32'h0000_0000)
    else $error("pair flag without 32-bit wrap");
  a_flag_sticky: assert property (odd_irq_flag_o && !odd_irq_flag_clr_i |=> odd_irq_flag_o)
    else $error("odd flag dropped without clear");
  a_dma_one_pulse: assert property (even_dma_req_o |=> !even_dma_req_o)
    else $error("dma request longer than a pulse");
  a_off_holds: assert property (
    !$past(even_timer_on_i) && !$past(even_timer_on_i, 2) && !$past(even_count_wr_i)
    && !$past(sys_rst_i) |-> $stable(even_count_value_o))
    else $error("even count moved while off");
endmodule

bind ctp_timer_pair ctp_timer_pair_asserts #(.PAIR_INDEX(PAIR_INDEX)) chk_u (.*);

// *** verification/test_ctp_timer_pair.sv ***
`timescale 1ns/1ns
module test_ctp_timer_pair
  import ctp_pkg::*;
;
  // clock, reset and stimulus
  logic clk_i = 0;
  logic sys_rst_i = 1;
  logic even_timer_on_i, even_cascade_select_i, even_clock_source_select_i;
  logic even_gate_enable_i, odd_timer_on_i, odd_clock_source_select_i, odd_gate_enable_i;
  logic even_count_wr_i, odd_count_wr_i, even_timer_irq_enable_i, odd_timer_irq_enable_i;
  logic even_irq_flag_clr_i, odd_irq_flag_clr_i;
  logic even_ext_clk_i, even_gate_i, odd_ext_clk_i, odd_gate_i;
  logic [1:0] even_prescale_select_i, odd_prescale_select_i;
  logic [2:0] even_timer_irq_priority_i, odd_timer_irq_priority_i;
  logic [15:0] even_period_value_i, odd_period_value_i, count_wdata_i;
  // design outputs
  logic [15:0] even_count_value_o, odd_count_value_o, even_time_base_o, odd_time_base_o;
  logic [2:0] even_irq_priority_o, odd_irq_priority_o;
  logic even_irq_flag_o, odd_irq_flag_o, even_irq_req_o, odd_irq_req_o;
  logic adc1_trigger_o, adc2_trigger_o, even_dma_req_o, odd_dma_req_o;
  logic even_time_base_tick_o, odd_time_base_tick_o;
  int err_count = 0;
  int n_tests = 0;

  ctp_timer_pair #(.PAIR_INDEX(0)) dut_u (.*);

  // 125 MHz clock
  always #4 clk_i = ~clk_i;

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic give_verdict();
    if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // idle inputs, five cycles of reset, cleared outputs
  task automatic do_reset();
    {even_timer_on_i, even_cascade_select_i, even_clock_source_select_i, even_gate_enable_i,
     odd_timer_on_i, odd_clock_source_select_i, odd_gate_enable_i, even_count_wr_i,
     odd_count_wr_i, even_timer_irq_enable_i, odd_timer_irq_enable_i, even_irq_flag_clr_i,
     odd_irq_flag_clr_i, even_ext_clk_i, even_gate_i, odd_ext_clk_i, odd_gate_i,
     even_prescale_select_i, odd_prescale_select_i, even_timer_irq_priority_i,
     odd_timer_irq_priority_i, even_period_value_i, odd_period_value_i, count_wdata_i} = '0;
    sys_rst_i = 1;
    cyc(5);
    sys_rst_i = 0;
    chk({odd_count_value_o, even_count_value_o}, 0);
    chk({even_irq_flag_o, odd_irq_flag_o, even_dma_req_o}, 0);
  endtask

  // split halves: even wraps at period 2, odd ticks every fourth cycle
  task automatic s_split();
    logic [15:0] exp_cnt [6] = '{0, 1, 2, 0, 1, 2};
    int pulses = 0;
    int t0 = 0;
    do_reset();
    even_period_value_i = 16'h0002;
    odd_period_value_i = 16'hffff;
    odd_prescale_select_i = 2'h1;
    even_timer_irq_enable_i = 1;
    even_timer_irq_priority_i = 3'h5;
    cyc(1);
    even_timer_on_i = 1;
    odd_timer_on_i = 1;
    for (int i = 0; i < 6; i++) begin
      cyc(1);
      pulses += even_dma_req_o;
      chk(even_count_value_o, exp_cnt[i]);
      chk(even_irq_flag_o, i > 2);
    end
    chk(even_irq_req_o, 1);
    chk(even_irq_priority_o, 3'h5);
    chk(pulses, 1);
    even_irq_flag_clr_i = 1;
    cyc(1);
    chk(even_irq_flag_o, 1);
    chk(even_dma_req_o, 1);
    cyc(1);
    even_irq_flag_clr_i = 0;
    chk(even_irq_flag_o, 0);
    while (odd_count_value_o != 16'h0002 && t0 < 50) begin
      cyc(1);
      t0++;
    end
    t0 = 0;
    while (odd_count_value_o == 16'h0002 && t0 < 50) begin
      cyc(1);
      t0++;
    end
    chk(t0, CTP_RATIO1);
  endtask

  // cascade: carry across words, 32-bit match raises the odd flag
  task automatic s_casc();
    logic [31:0] exp_cnt [6] = '{32'h0000_fffe, 32'h0000_ffff, 32'h0001_0000,
                                 32'h0001_0001, 32'h0000_0000, 32'h0000_0001};
    do_reset();
    even_cascade_select_i = 1;
    odd_timer_on_i = 1;
    odd_prescale_select_i = 2'h3;
    odd_clock_source_select_i = 1;
    odd_gate_enable_i = 1;
    even_period_value_i = 16'h0001;
    odd_period_value_i = 16'h0001;
    even_timer_irq_enable_i = 1;
    odd_timer_irq_enable_i = 1;
    odd_timer_irq_priority_i = 3'h6;
    count_wdata_i = 16'hfffe;
    even_count_wr_i = 1;
    cyc(1);
    even_count_wr_i = 0;
    even_timer_on_i = 1;
    for (int i = 0; i < 6; i++) begin
      cyc(1);
      chk({odd_count_value_o, even_count_value_o}, exp_cnt[i]);
      chk(even_irq_flag_o, 0);
      chk({adc1_trigger_o, adc2_trigger_o}, {i == 4, 1'b0});
      chk(odd_dma_req_o, i == 4);
      chk({odd_time_base_tick_o, even_time_base_tick_o}, {i == 2 || i == 4, i > 0});
      if (i > 0) chk({odd_time_base_o, even_time_base_o}, exp_cnt[i - 1]);
    end
    chk(odd_irq_flag_o, 1);
    cyc(1);
    chk({odd_irq_req_o, even_irq_req_o}, 2'b10);
    chk(odd_irq_priority_o, 3'h6);
  endtask

  // gated accumulation, then external clock source
  task automatic s_src();
    do_reset();
    even_period_value_i = 16'hffff;
    even_gate_enable_i = 1;
    even_timer_on_i = 1;
    cyc(6);
    chk(even_count_value_o, 0);
    even_gate_i = 1;
    cyc(4);
    even_gate_i = 0;
    cyc(4);
    chk(even_count_value_o, 4);
    chk(even_irq_flag_o, 1);
    do_reset();
    even_period_value_i = 16'hffff;
    even_clock_source_select_i = 1;
    even_timer_on_i = 1;
    repeat (5) begin
      cyc(1);
      even_ext_clk_i = 1;
      cyc(1);
      even_ext_clk_i = 0;
    end
    cyc(3);
    chk(even_count_value_o, 5);
  endtask

  // main sequence
  initial begin
    s_split();
    s_casc();
    s_src();
    give_verdict();
  end

  // watchdog
  initial begin
    cyc(2000);
    err_count++;
    give_verdict();
  end
endmodule
